// ### design/mbv_voting.v
// Purpose: Per-group maintenance bypass selection and two-of-four coincidence voting
// Assumes: Packets arrive as one-cycle strobes; switch levels come from outside the clock
// Notes:   The group stays with its last good packet until the response timer expires
//
// Contract
// - Four channel votes per function; actuate when at least two indicate trip.
// - Out of service with switch at bypass sends no-trip, ignoring computed result.
// - Out of service with switch at trip sends trip, ignoring computed result.
// - Bypassed channel keeps threshold; two of remaining three must trip.
// - Forced-trip channel keeps threshold; any one other trip actuates.
// - In service, the computed algorithm result is forwarded to the voter.
// - No valid response raises an alarm; vote follows the trip/bypass switch.
// - Out-of-service status is taken only from the packet field.
// - Parameter writes allowed only while the module is out of service.
// - Trip/bypass switch position becomes a synchronised logic level for all modules.
// - Bypassed and out-of-service status is reported to control and display systems.
// - Breaker undervoltage trip outputs stay unasserted while trip logic is tested.
// - Actuation divisions have no bypass path; only channel selection is bypassable.
// - Cooling action completes only after valve open feedback is received.
`timescale 1ns/10ps
`include "mbv_consts.vh"
`default_nettype none

module mbv_voting (
    input  wire                                 clk,
    input  wire                                 reset,
    input  wire [`MBV_GROUPS-1:0]               pktValid,
    input  wire [`MBV_GROUPS*`MBV_PKT_W-1:0]    pktData,
    input  wire [`MBV_GROUPS*`MBV_FUNCS-1:0]    tripBypassSwitch,
    input  wire                                 paramWriteReq,
    input  wire [1:0]                           paramWriteGroup,
    input  wire                                 tripLogicTest,
    input  wire                                 coolingFunctionIndex,
    input  wire [1:0]                           valveOpenFeedback,
    output reg  [`MBV_GROUPS*`MBV_FUNCS-1:0]    voteToVoter,
    output reg  [`MBV_FUNCS-1:0]                actuate,
    output reg  [`MBV_FUNCS-1:0]                breakerUvTrip,
    output reg  [`MBV_GROUPS-1:0]               noResponseAlarm,
    output reg  [`MBV_GROUPS-1:0]               outOfServiceStatus,
    output reg  [`MBV_GROUPS*`MBV_FUNCS-1:0]    bypassedStatus,
    output reg  [`MBV_GROUPS*`MBV_FUNCS-1:0]    forcedTripStatus,
    output reg  [`MBV_GROUPS*`MBV_FUNCS*2-1:0]  voteSource,
    output reg                                  paramWriteGrant,
    output reg                                  coolingComplete
);

    localparam GF = `MBV_GROUPS * `MBV_FUNCS;
    localparam [`MBV_TIMER_W-1:0] TIMEOUT = `MBV_RESP_TIMEOUT_CYC;

    // Population count of four votes compared against the fixed threshold
    function coincidence;
        input [3:0] v;
        reg   [2:0] n;
        begin
            n = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
            coincidence = (n >= `MBV_VOTE_THRESHOLD);
        end
    endfunction

    // Two-stage synchronisers for switch and valve pins
    reg [GF-1:0] swMeta;
    reg [GF-1:0] swLevel;
    reg [1:0]    valveMeta;
    reg [1:0]    valveLevel;
    reg          testMeta;
    reg          testLevel;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            swMeta     <= {GF{1'b0}};
            swLevel    <= {GF{1'b0}};
            valveMeta  <= 2'h0;
            valveLevel <= 2'h0;
            testMeta   <= 1'b0;
            testLevel  <= 1'b0;
        end else begin
            swMeta     <= tripBypassSwitch;
            swLevel    <= swMeta;
            valveMeta  <= valveOpenFeedback;
            valveLevel <= valveMeta;
            testMeta   <= tripLogicTest;
            testLevel  <= testMeta;
        end
    end

    // Latched packet contents and response timers per group
    reg [`MBV_FUNCS-1:0]     pktTrip [0:`MBV_GROUPS-1];
    reg [`MBV_GROUPS-1:0]    pktOos;
    reg [`MBV_TIMER_W-1:0]   respTimer [0:`MBV_GROUPS-1];
    reg [`MBV_GROUPS-1:0]    respValid;
    integer g;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pktOos    <= {`MBV_GROUPS{1'b0}};
            respValid <= {`MBV_GROUPS{1'b0}};
            for (g = 0; g < `MBV_GROUPS; g = g + 1) begin
                pktTrip[g]   <= {`MBV_FUNCS{1'b0}};
                respTimer[g] <= {`MBV_TIMER_W{1'b0}};
            end
        end else begin
            for (g = 0; g < `MBV_GROUPS; g = g + 1) begin
                if (pktValid[g]) begin
                    pktTrip[g]   <= pktData[g*`MBV_PKT_W+`MBV_PKT_TRIP_LSB +: `MBV_FUNCS];
                    pktOos[g]    <= pktData[g*`MBV_PKT_W+`MBV_PKT_OOS_BIT];
                    respTimer[g] <= {`MBV_TIMER_W{1'b0}};
                    respValid[g] <= 1'b1;
                end else if (respTimer[g] == TIMEOUT - 1'b1) begin
                    // Missing packets count as an invalid response
                    respValid[g] <= 1'b0;
                end else begin
                    respTimer[g] <= respTimer[g] + 1'b1;
                end
            end
        end
    end

    // Per-function selection; out of service only honoured with a valid packet
    reg [GF-1:0]   next_vote;
    reg [GF-1:0]   next_bypassed;
    reg [GF-1:0]   next_forced;
    reg [GF*2-1:0] next_source;
    reg [`MBV_FUNCS-1:0] next_actuate;
    reg [3:0]      col;
    integer i;
    integer j;

    always @* begin
        next_vote     = {GF{1'b0}};
        next_bypassed = {GF{1'b0}};
        next_forced   = {GF{1'b0}};
        next_source   = {GF*2{1'b0}};
        next_actuate  = {`MBV_FUNCS{1'b0}};
        col           = 4'h0;
        for (i = 0; i < `MBV_GROUPS; i = i + 1) begin
            for (j = 0; j < `MBV_FUNCS; j = j + 1) begin
                if (!respValid[i]) begin
                    next_vote[i*`MBV_FUNCS+j] = swLevel[i*`MBV_FUNCS+j];
                    next_source[(i*`MBV_FUNCS+j)*2 +: 2] = `MBV_SRC_NO_RESPONSE;
                end else if (pktOos[i] && swLevel[i*`MBV_FUNCS+j]) begin
                    next_vote[i*`MBV_FUNCS+j]   = 1'b1;
                    next_forced[i*`MBV_FUNCS+j] = 1'b1;
                    next_source[(i*`MBV_FUNCS+j)*2 +: 2] = `MBV_SRC_FORCED_TRIP;
                end else if (pktOos[i]) begin
                    next_vote[i*`MBV_FUNCS+j]     = 1'b0;
                    next_bypassed[i*`MBV_FUNCS+j] = 1'b1;
                    next_source[(i*`MBV_FUNCS+j)*2 +: 2] = `MBV_SRC_BYPASS;
                end else begin
                    next_vote[i*`MBV_FUNCS+j] = pktTrip[i][j];
                    next_source[(i*`MBV_FUNCS+j)*2 +: 2] = `MBV_SRC_COMPUTED;
                end
            end
        end
        // Threshold never moves with bypass or forced trip
        for (j = 0; j < `MBV_FUNCS; j = j + 1) begin
            for (i = 0; i < `MBV_GROUPS; i = i + 1) begin
                col[i] = next_vote[i*`MBV_FUNCS+j];
            end
            next_actuate[j] = coincidence(col);
        end
    end

    // Registered outputs; voting uses votes of the same cycle for least latency
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            voteToVoter        <= {GF{1'b0}};
            actuate            <= {`MBV_FUNCS{1'b0}};
            breakerUvTrip      <= {`MBV_FUNCS{1'b0}};
            noResponseAlarm    <= {`MBV_GROUPS{1'b0}};
            outOfServiceStatus <= {`MBV_GROUPS{1'b0}};
            bypassedStatus     <= {GF{1'b0}};
            forcedTripStatus   <= {GF{1'b0}};
            voteSource         <= {GF*2{1'b0}};
            paramWriteGrant    <= 1'b0;
            coolingComplete    <= 1'b0;
        end else begin
            voteToVoter     <= next_vote;
            // No bypass term on the actuation path itself
            actuate         <= next_actuate;
            breakerUvTrip   <= testLevel ? {`MBV_FUNCS{1'b0}} : next_actuate;
            noResponseAlarm <= ~respValid;
            outOfServiceStatus <= pktOos & respValid;
            bypassedStatus     <= next_bypassed;
            forcedTripStatus   <= next_forced;
            voteSource         <= next_source;
            paramWriteGrant    <= paramWriteReq & pktOos[paramWriteGroup]
                                  & respValid[paramWriteGroup];
            coolingComplete    <= next_actuate[coolingFunctionIndex]
                                  & (&valveLevel);
        end
    end

endmodule

`default_nettype wire

// ### design/mbv_consts.vh
// Purpose: Constants for the maintenance bypass and coincidence voting block
// Assumes: Four separation groups, a fixed number of safety functions per group
// Notes:   Timing counts are in cycles of the 10 MHz clock
`ifndef MBV_CONSTS_VH
`define MBV_CONSTS_VH

`define MBV_GROUPS          4
`define MBV_FUNCS           4
`define MBV_VOTE_THRESHOLD  3'h2
`define MBV_CLK_PERIOD_NS   100
// Packet response timeout, 50 us, rounded down to whole cycles
`define MBV_RESP_TIMEOUT_US 50
// Sized to the timer width so the compare never meets a 32-bit value
`define MBV_RESP_TIMEOUT_CYC 10'h1f4
`define MBV_TIMER_W         10
// Packet field positions: [FUNCS-1:0] algorithm trips, then out-of-service bit
`define MBV_PKT_TRIP_LSB    0
`define MBV_PKT_OOS_BIT     4
`define MBV_PKT_W           5
// Vote source codes reported per function
`define MBV_SRC_COMPUTED    2'h0
`define MBV_SRC_BYPASS      2'h1
`define MBV_SRC_FORCED_TRIP 2'h2
`define MBV_SRC_NO_RESPONSE 2'h3

`endif

// ### test/mbv_voting_props.sv
// Purpose: Port assertions for mbv_voting
// Assumes: Synchroniser lag is covered by four-cycle holds
// Notes:   Bound to every mbv_voting instance
`timescale 1ns/10ps
`include "mbv_consts.vh"
`default_nettype none
module mbv_voting_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  pktValid,
    input wire logic        tripLogicTest,
    input wire logic [1:0]  valveOpenFeedback,
    input wire logic [15:0] voteToVoter,
    input wire logic [3:0]  actuate,
    input wire logic [3:0]  breakerUvTrip,
    input wire logic [3:0]  noResponseAlarm,
    input wire logic [3:0]  outOfServiceStatus,
    input wire logic [15:0] bypassedStatus,
    input wire logic [15:0] forcedTripStatus,
    input wire logic [31:0] voteSource,
    input wire logic        paramWriteGrant,
    input wire logic        coolingComplete
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    function automatic logic maj(input logic [15:0] v, input int f);
        return (v[f] + v[4+f] + v[8+f] + v[12+f]) >= 2;
    endfunction
    sequence s_test_held; tripLogicTest [*4]; endsequence
    sequence s_test_idle; !tripLogicTest [*4]; endsequence
    for (genvar f = 0; f < 4; f++) begin : g_fn
        a_vote_thresh: assert property ($stable(voteToVoter) |-> actuate[f] == maj(voteToVoter, f))
            else $error("actuate disagrees with vote count");
    end
    a_bypass_notrip: assert property ((bypassedStatus & voteToVoter) == 16'h0)
        else $error("bypassed channel votes trip");
    a_forced_trip: assert property ((forcedTripStatus & ~voteToVoter) == 16'h0)
        else $error("forced channel votes no-trip");
    a_uv_blocked: assert property (s_test_held |-> breakerUvTrip == 4'h0)
        else $error("breaker trip during test");
    a_uv_follows: assert property (s_test_idle |-> breakerUvTrip == actuate)
        else $error("breaker trip differs from actuate");
    a_grant_gate: assert property ((outOfServiceStatus == 4'h0) [*2] |-> !paramWriteGrant)
        else $error("write granted while in service");
    a_alarm_clear: assert property (pktValid[0] |-> ##2 !noResponseAlarm[0])
        else $error("alarm stays after packet");
    a_cool_valves: assert property ((valveOpenFeedback != 2'h3) [*4] |-> !coolingComplete)
        else $error("cooling complete without valves open");
    a_source_code: assert property (forcedTripStatus[0] |-> voteSource[1:0] == `MBV_SRC_FORCED_TRIP)
        else $error("wrong vote source code");
endmodule
bind mbv_voting mbv_voting_props chk_u (.*);
`default_nettype wire

// ### test/mbv_func_model.sv
// Purpose: Four function modules sending a packet every 16 cycles
// Assumes: Silent groups send nothing
// Notes:   Data between strobes is inverted so stale bits never look valid
`timescale 1ns/10ps
`default_nettype none
module mbv_func_model (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] tripIn,
    input wire logic [3:0]  oosIn,
    input wire logic [3:0]  silent,
    output var logic [3:0]  pktValid,
    output var logic [19:0] pktData
);
    logic [3:0] tick;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tick <= 4'h0;
            pktValid <= 4'h0;
            pktData <= 20'h0;
        end else begin
            tick <= tick + 4'h1;
            for (int g = 0; g < 4; g++) begin
                pktValid[g] <= (tick == 4'h0) && !silent[g];
                pktData[g*5+:5] <= (tick == 4'h0 && !silent[g]) ? {oosIn[g], tripIn[g*4+:4]}
                                                                : ~pktData[g*5+:5];
            end
        end
    end
endmodule
`default_nettype wire

// ### test/mbv_voting_tb.sv
// Purpose: Self-checking bench for mbv_voting
// Assumes: Emergency cooling is function 0 until the last cooling check selects function 1
// Notes:   Waits of 40 cycles cover packet period plus pipeline
`timescale 1ns/10ps
`default_nettype none
module mbv_voting_tb;
    logic clk = 0, reset = 1, req = 0, tst = 0, cfi = 0;
    logic [15:0] tripIn = 0, sw = 16'hffff, vote, byp, frc;
    logic [3:0] oosIn = 0, silent = 0, pv, act, uv, alarm, oos;
    logic [1:0] grp = 0, valve = 0;
    logic [19:0] pd;
    logic [31:0] src;
    logic grant, cool;
    integer err_count = 0, cmp_count = 0, cyc = 0;
    always #50 clk = ~clk;
    mbv_func_model fm_u (.clk(clk), .reset(reset), .tripIn(tripIn), .oosIn(oosIn),
        .silent(silent), .pktValid(pv), .pktData(pd));
    mbv_voting dut_u (.clk(clk), .reset(reset), .pktValid(pv), .pktData(pd),
        .tripBypassSwitch(sw), .paramWriteReq(req), .paramWriteGroup(grp),
        .tripLogicTest(tst), .coolingFunctionIndex(cfi), .valveOpenFeedback(valve),
        .voteToVoter(vote), .actuate(act), .breakerUvTrip(uv), .noResponseAlarm(alarm),
        .outOfServiceStatus(oos), .bypassedStatus(byp), .forcedTripStatus(frc),
        .voteSource(src), .paramWriteGrant(grant), .coolingComplete(cool));
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task run(input integer n, input integer t);
        repeat (n) @(posedge clk);
        if (t > 0) $display("test %0d done", t);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        run(3, 0);
        reset <= 0;
        tripIn <= 16'h0011;
        run(40, 0);
        chk("vote", 16'h0011, vote);
        chk("actuate", 16'h1, {12'h0, act});
        tripIn <= 16'h0001;
        run(40, 1);
        chk("actuate", 16'h0, {12'h0, act});
        oosIn <= 4'h1;
        sw <= 16'hfffe;
        tripIn <= 16'h0011;
        run(40, 0);
        // Group 0: function 0 switch at bypass, functions 1-3 still at trip
        chk("vote", 16'h001e, vote);
        chk("actuate", 16'h0, {12'h0, act});
        chk("bypassed", 16'h0001, byp);
        chk("forced", 16'h000e, frc);
        chk("oos", 16'h1, {12'h0, oos});
        tripIn <= 16'h0111;
        run(40, 2);
        chk("actuate", 16'h1, {12'h0, act});
        sw <= 16'hffff;
        tripIn <= 16'h0000;
        run(40, 0);
        chk("vote", 16'h000f, vote);
        chk("actuate", 16'h0, {12'h0, act});
        tripIn <= 16'h1000;
        run(40, 0);
        chk("actuate", 16'h1, {12'h0, act});
        chk("forced", 16'h000f, frc);
        chk("source", 16'h00aa, src[15:0]);
        req <= 1;
        run(6, 0);
        chk("grant", 16'h1, {15'h0, grant});
        grp <= 2'h1;
        run(6, 3);
        chk("grant", 16'h0, {15'h0, grant});
        tst <= 1;
        run(8, 0);
        chk("uvtrip", 16'h0, {12'h0, uv});
        tst <= 0;
        valve <= 2'h3;
        run(8, 0);
        chk("uvtrip", 16'h1, {12'h0, uv});
        chk("cooled", 16'h1, {15'h0, cool});
        valve <= 2'h1;
        run(8, 4);
        chk("cooled", 16'h0, {15'h0, cool});
        // Function 1 as cooling: not actuated, so open valves must not complete it
        cfi <= 1'h1;
        valve <= 2'h3;
        run(8, 0);
        chk("cooled", 16'h0, {15'h0, cool});
        oosIn <= 4'h0;
        tripIn <= 16'h0000;
        silent <= 4'h8;
        sw <= 16'h1000;
        run(600, 5);
        chk("alarm", 16'h8, {12'h0, alarm});
        chk("vote", 16'h1000, vote);
        chk("source", 16'hff00, src[31:16]);
        close_out;
    end
endmodule
`default_nettype wire
